// File: verilog/rish_regs.vh
// Register map, field positions, reset values and constants of the reference select block.
// ==========================================================================================
// Behaviour
// - Mode 00 manual, 01 auto, 10 short-term holdover, 11 auto with holdover.
// - Manual modes select input 0 to 3 from the choice field, reset 00.
// - When the mode low bit is 1 the manual choice field is ignored.
// - Mode 11 starts the hold-off counter on signal loss; switch at zero.
// - Counter decrements once per tick of the divided oscillator pulse train.
// - After each zero transition the counter reloads from the count register.
// - Reset values: hold-off count 0x80, reference divider 10.
// - Two-bit priority per input, 11 highest, ties favour input 0 first.
// - With mode low bit 0 the revertive switching setting is disregarded.
`ifndef RISH_REGS_VH
`define RISH_REGS_VH

// ==========================================================================================
// Byte addresses on the register bus.
// ==========================================================================================
`define RISH_ADR_CTRL      8'h00
`define RISH_ADR_HOLDOFF   8'h04
`define RISH_ADR_PRIO      8'h08
`define RISH_ADR_STATUS    8'h0c
`define RISH_ADR_IRQ_STAT  8'h10
`define RISH_ADR_IRQ_MASK  8'h14

// ==========================================================================================
// Control word fields.
// ==========================================================================================
`define RISH_CTRL_MODE_LSB    0
`define RISH_CTRL_CHOICE_LSB  2
`define RISH_CTRL_REVERT_BIT  4
`define RISH_CTRL_DIV_LSB     8

// ==========================================================================================
// Selection modes.
// ==========================================================================================
`define RISH_MODE_MANUAL     2'h0
`define RISH_MODE_AUTO       2'h1
`define RISH_MODE_SHORT_HOLD 2'h2
`define RISH_MODE_AUTO_HOLD  2'h3

// ==========================================================================================
// Reset values.
// ==========================================================================================
`define RISH_RST_MODE     2'h0
`define RISH_RST_CHOICE   2'h0
`define RISH_RST_REVERT   1'h0
`define RISH_RST_DIV      2'h2
`define RISH_RST_HOLDOFF  8'h80
`define RISH_RST_PRIO     8'h1b
`define RISH_RST_MASK     3'h0

// ==========================================================================================
// Interrupt status bits.
// ==========================================================================================
`define RISH_IRQ_SWITCH  0
`define RISH_IRQ_LOSS    1
`define RISH_IRQ_NOREF   2

// ==========================================================================================
// Reference divider exponents (divide by two to the power given).
// ==========================================================================================
`define RISH_DIV_EXP0  15
`define RISH_DIV_EXP1  16
`define RISH_DIV_EXP2  17
`define RISH_DIV_EXP3  18

`endif

// File: verilog/rish_tick_div.v
// Reference divider that turns the oscillator pulse train into hold-off counter ticks.
`include "rish_regs.vh"

module rish_tick_div #(
  parameter EXP0 = `RISH_DIV_EXP0,
  parameter EXP1 = `RISH_DIV_EXP1,
  parameter EXP2 = `RISH_DIV_EXP2,
  parameter EXP3 = `RISH_DIV_EXP3
) (
  input  wire       clk_in,
  input  wire       sys_rst_in,
  input  wire       osc_pulse_in,
  input  wire       run_in,
  input  wire [1:0] div_sel_in,
  output wire       tick_out
);

  reg         osc_prev_q;
  reg  [18:0] cnt_q;
  reg  [18:0] cnt_d;
  reg  [18:0] limit;
  wire        osc_edge;

  // ========================================================================================
  // Oscillator edge detection.
  // ========================================================================================
  // Each rising edge of the oscillator pulse train counts as one pulse.
  assign osc_edge = osc_pulse_in & ~osc_prev_q;

  // Terminal count for the selected divide ratio.
  always @* begin
    case (div_sel_in)
      2'h0:    limit = (19'h1 << EXP0) - 19'h1;
      2'h1:    limit = (19'h1 << EXP1) - 19'h1;
      2'h2:    limit = (19'h1 << EXP2) - 19'h1;
      default: limit = (19'h1 << EXP3) - 19'h1;
    endcase
  end

  // A tick falls on the pulse that completes the divide ratio.
  assign tick_out = run_in & osc_edge & (cnt_q >= limit);

  // Next pulse count; it restarts whenever the counter is idle so each wait is whole.
  always @* begin
    cnt_d = cnt_q;
    if (!run_in) begin
      cnt_d = 19'h0;
    end else if (osc_edge) begin
      if (cnt_q >= limit) begin
        cnt_d = 19'h0;
      end else begin
        cnt_d = cnt_q + 19'h1;
      end
    end
  end

  // Pulse counter and edge history.
  always @(posedge clk_in) begin
    if (sys_rst_in) begin
      osc_prev_q <= 1'b0;
      cnt_q      <= 19'h0;
    end else begin
      osc_prev_q <= osc_pulse_in;
      cnt_q      <= cnt_d;
    end
  end

endmodule // rish_tick_div

// File: verilog/rish_ref_select.v
// Reference input selection with hold-off timing and a classic Wishbone register slave.
`include "rish_regs.vh"

module rish_ref_select #(
  parameter DIV_EXP0 = `RISH_DIV_EXP0,
  parameter DIV_EXP1 = `RISH_DIV_EXP1,
  parameter DIV_EXP2 = `RISH_DIV_EXP2,
  parameter DIV_EXP3 = `RISH_DIV_EXP3
) (
  input  wire        clk_in,
  input  wire        sys_rst_in,
  // Classic Wishbone slave.
  input  wire        wb_cyc_in,
  input  wire        wb_stb_in,
  input  wire        wb_we_in,
  input  wire [7:0]  wb_adr_in,
  input  wire [3:0]  wb_sel_in,
  input  wire [31:0] wb_dat_in,
  output reg  [31:0] wb_dat_out,
  output reg         wb_ack_out,
  // Input monitoring and oscillator pulse train.
  input  wire [3:0]  signal_lost_flag_in,
  input  wire        osc_pulse_in,
  // Selection results.
  output reg  [1:0]  ref_sel_out,
  output reg         holdover_out,
  output reg         switch_pulse_out,
  output wire        irq_out
);

  // ========================================================================================
  // State encoding.
  // ========================================================================================
  localparam [2:0] ST_TRACK   = 3'h1;
  localparam [2:0] ST_HOLDOFF = 3'h2;
  localparam [2:0] ST_NOREF   = 3'h4;

  // ========================================================================================
  // Registers.
  // ========================================================================================
  reg  [1:0]  ref_select_mode_q;
  reg  [1:0]  manual_ref_choice_q;
  reg         revert_switch_enable_q;
  reg  [1:0]  holdoff_ref_divider_q;
  reg  [7:0]  holdoff_count_q;
  reg  [7:0]  input_priority_q;
  reg  [2:0]  irq_stat_q;
  reg  [2:0]  irq_stat_d;
  reg  [2:0]  irq_mask_q;
  reg  [7:0]  cnt_q;
  reg  [7:0]  cnt_d;
  reg  [2:0]  state_q;
  reg  [2:0]  state_d;
  reg  [1:0]  auto_sel_q;
  reg  [1:0]  auto_sel_d;
  reg         switch_ev;
  reg         noref_ev;
  reg  [3:0]  lost_prev_q;
  reg  [31:0] rd_data;

  wire        bus_req;
  wire        wr_stb;
  wire        rd_stb;
  wire        auto_mode;
  wire        hold_mode;
  wire        revert_on;
  wire        tick;
  wire        cur_lost;
  wire        loss_ev;
  wire [2:0]  best;
  wire        best_ok;
  wire [1:0]  best_idx;
  wire        best_higher;

  // ========================================================================================
  // Helper functions.
  // ========================================================================================
  // Returns the priority field of one input.
  function [1:0] prio_of;
    input [7:0] prio;
    input [1:0] idx;
    begin
      prio_of = prio[{idx, 1'b0} +: 2];
    end
  endfunction

  // Picks the highest-priority input that still has a signal; ties go to the lower index.
  // The result is {found, index}.
  function [2:0] pick_best;
    input [3:0] lost;
    input [7:0] prio;
    integer     p;
    integer     i;
    reg         found;
    reg  [1:0]  idx;
    begin
      found = 1'b0;
      idx   = 2'h0;
      for (p = 3; p >= 0; p = p - 1) begin
        for (i = 0; i < 4; i = i + 1) begin
          if (!found && !lost[i] && (prio_of(prio, i[1:0]) == p[1:0])) begin
            found = 1'b1;
            idx   = i[1:0];
          end
        end
      end
      pick_best = {found, idx};
    end
  endfunction

  // ========================================================================================
  // Mode decode.
  // ========================================================================================
  // The low mode bit marks the automatic modes; 11 adds the hold-off delay.
  assign auto_mode = ref_select_mode_q[0];
  assign hold_mode = (ref_select_mode_q == `RISH_MODE_AUTO_HOLD);
  // Revertive switching has no meaning outside the automatic modes.
  assign revert_on = revert_switch_enable_q & auto_mode;

  // ========================================================================================
  // Tick generator.
  // ========================================================================================
  // Ticks run only while the hold-off counter is counting down.
  rish_tick_div #(
    .EXP0 (DIV_EXP0),
    .EXP1 (DIV_EXP1),
    .EXP2 (DIV_EXP2),
    .EXP3 (DIV_EXP3)
  ) u_tick_div (
    .clk_in       (clk_in),
    .sys_rst_in   (sys_rst_in),
    .osc_pulse_in (osc_pulse_in),
    .run_in       (state_q == ST_HOLDOFF),
    .div_sel_in   (holdoff_ref_divider_q),
    .tick_out     (tick)
  );

  // ========================================================================================
  // Automatic selection.
  // ========================================================================================
  assign best        = pick_best(signal_lost_flag_in, input_priority_q);
  assign best_ok     = best[2];
  assign best_idx    = best[1:0];
  assign cur_lost    = signal_lost_flag_in[auto_sel_q];
  assign loss_ev     = cur_lost & ~lost_prev_q[auto_sel_q];
  assign best_higher = best_ok &&
                       (prio_of(input_priority_q, best_idx) >
                        prio_of(input_priority_q, auto_sel_q));

  // Next state of the automatic selector and its hold-off counter.
  always @* begin
    state_d    = state_q;
    auto_sel_d = auto_sel_q;
    cnt_d      = cnt_q;
    switch_ev  = 1'b0;
    noref_ev   = 1'b0;
    case (state_q)
      ST_TRACK: begin
        cnt_d = holdoff_count_q;
        if (!auto_mode) begin
          state_d = ST_TRACK;
        end else if (cur_lost && hold_mode) begin
          state_d = ST_HOLDOFF;
        end else if (cur_lost) begin
          if (best_ok) begin
            auto_sel_d = best_idx;
            switch_ev  = 1'b1;
          end else begin
            state_d  = ST_NOREF;
            noref_ev = 1'b1;
          end
        end else if (revert_on && best_higher) begin
          auto_sel_d = best_idx;
          switch_ev  = 1'b1;
        end
      end
      ST_HOLDOFF: begin
        if (!hold_mode) begin
          state_d = ST_TRACK;
          cnt_d   = holdoff_count_q;
        end else if (!cur_lost) begin
          state_d = ST_TRACK;
          cnt_d   = holdoff_count_q;
        end else if (tick) begin
          if (cnt_q <= 8'h01) begin
            cnt_d = holdoff_count_q;
            if (best_ok) begin
              state_d    = ST_TRACK;
              auto_sel_d = best_idx;
              switch_ev  = 1'b1;
            end else begin
              state_d  = ST_NOREF;
              noref_ev = 1'b1;
            end
          end else begin
            cnt_d = cnt_q - 8'h01;
          end
        end
      end
      ST_NOREF: begin
        cnt_d = holdoff_count_q;
        if (!auto_mode) begin
          state_d = ST_TRACK;
        end else if (!cur_lost) begin
          state_d = ST_TRACK;
        end else if (best_ok) begin
          state_d    = ST_TRACK;
          auto_sel_d = best_idx;
          switch_ev  = 1'b1;
        end
      end
      default: begin
        state_d = ST_TRACK;
        cnt_d   = holdoff_count_q;
      end
    endcase
  end

  // Selector state, counter and loss history.
  always @(posedge clk_in) begin
    if (sys_rst_in) begin
      state_q     <= ST_TRACK;
      auto_sel_q  <= 2'h0;
      cnt_q       <= `RISH_RST_HOLDOFF;
      lost_prev_q <= 4'h0;
    end else begin
      state_q     <= state_d;
      auto_sel_q  <= auto_mode ? auto_sel_d : manual_ref_choice_q;
      cnt_q       <= cnt_d;
      lost_prev_q <= signal_lost_flag_in;
    end
  end

  // ========================================================================================
  // Reference output.
  // ========================================================================================
  // Manual modes follow the choice field; automatic modes ignore it.
  always @(posedge clk_in) begin
    if (sys_rst_in) begin
      ref_sel_out      <= 2'h0;
      holdover_out     <= 1'b0;
      switch_pulse_out <= 1'b0;
    end else begin
      ref_sel_out      <= auto_mode ? auto_sel_d : manual_ref_choice_q;
      holdover_out     <= auto_mode ? (state_d != ST_TRACK)
                                    : signal_lost_flag_in[manual_ref_choice_q];
      switch_pulse_out <= switch_ev;
    end
  end

  // ========================================================================================
  // Wishbone slave.
  // ========================================================================================
  assign bus_req = wb_cyc_in & wb_stb_in & ~wb_ack_out;
  assign wr_stb  = bus_req & wb_we_in;
  assign rd_stb  = bus_req & ~wb_we_in;

  // Read multiplexer; unmapped addresses read as zero.
  always @* begin
    rd_data = 32'h0;
    case (wb_adr_in)
      `RISH_ADR_CTRL: begin
        rd_data[`RISH_CTRL_MODE_LSB +: 2]   = ref_select_mode_q;
        rd_data[`RISH_CTRL_CHOICE_LSB +: 2] = manual_ref_choice_q;
        rd_data[`RISH_CTRL_REVERT_BIT]      = revert_switch_enable_q;
        rd_data[`RISH_CTRL_DIV_LSB +: 2]    = holdoff_ref_divider_q;
      end
      `RISH_ADR_HOLDOFF:  rd_data[7:0] = holdoff_count_q;
      `RISH_ADR_PRIO:     rd_data[7:0] = input_priority_q;
      `RISH_ADR_STATUS: begin
        rd_data[1:0]   = ref_sel_out;
        rd_data[5:2]   = signal_lost_flag_in;
        rd_data[6]     = holdover_out;
        rd_data[10:8]  = state_q;
        rd_data[23:16] = cnt_q;
      end
      `RISH_ADR_IRQ_STAT: rd_data[2:0] = irq_stat_q;
      `RISH_ADR_IRQ_MASK: rd_data[2:0] = irq_mask_q;
      default:            rd_data = 32'h0;
    endcase
  end

  // Bus answer: acknowledge one cycle after the request, then drop for a cycle.
  always @(posedge clk_in) begin
    if (sys_rst_in) begin
      wb_ack_out <= 1'b0;
      wb_dat_out <= 32'h0;
    end else begin
      wb_ack_out <= bus_req;
      if (rd_stb) begin
        wb_dat_out <= rd_data;
      end
    end
  end

  // Configuration registers, written per byte lane.
  always @(posedge clk_in) begin
    if (sys_rst_in) begin
      ref_select_mode_q      <= `RISH_RST_MODE;
      manual_ref_choice_q    <= `RISH_RST_CHOICE;
      revert_switch_enable_q <= `RISH_RST_REVERT;
      holdoff_ref_divider_q  <= `RISH_RST_DIV;
      holdoff_count_q        <= `RISH_RST_HOLDOFF;
      input_priority_q       <= `RISH_RST_PRIO;
      irq_mask_q             <= `RISH_RST_MASK;
    end else if (wr_stb) begin
      case (wb_adr_in)
        `RISH_ADR_CTRL: begin
          if (wb_sel_in[0]) begin
            ref_select_mode_q      <= wb_dat_in[`RISH_CTRL_MODE_LSB +: 2];
            manual_ref_choice_q    <= wb_dat_in[`RISH_CTRL_CHOICE_LSB +: 2];
            revert_switch_enable_q <= wb_dat_in[`RISH_CTRL_REVERT_BIT];
          end
          if (wb_sel_in[1]) begin
            holdoff_ref_divider_q <= wb_dat_in[`RISH_CTRL_DIV_LSB +: 2];
          end
        end
        `RISH_ADR_HOLDOFF: begin
          if (wb_sel_in[0]) begin
            holdoff_count_q <= wb_dat_in[7:0];
          end
        end
        `RISH_ADR_PRIO: begin
          if (wb_sel_in[0]) begin
            input_priority_q <= wb_dat_in[7:0];
          end
        end
        `RISH_ADR_IRQ_MASK: begin
          if (wb_sel_in[0]) begin
            irq_mask_q <= wb_dat_in[2:0];
          end
        end
        default: begin
          irq_mask_q <= irq_mask_q;
        end
      endcase
    end
  end

  // ========================================================================================
  // Interrupts.
  // ========================================================================================
  // A read of the status word clears it; a new event in the same cycle still sets.
  always @* begin
    irq_stat_d = irq_stat_q;
    if (rd_stb && (wb_adr_in == `RISH_ADR_IRQ_STAT)) begin
      irq_stat_d = 3'h0;
    end
    if (switch_ev) begin
      irq_stat_d[`RISH_IRQ_SWITCH] = 1'b1;
    end
    if (loss_ev) begin
      irq_stat_d[`RISH_IRQ_LOSS] = 1'b1;
    end
    if (noref_ev) begin
      irq_stat_d[`RISH_IRQ_NOREF] = 1'b1;
    end
  end

  // Sticky interrupt status.
  always @(posedge clk_in) begin
    if (sys_rst_in) begin
      irq_stat_q <= 3'h0;
    end else begin
      irq_stat_q <= irq_stat_d;
    end
  end

  // Level interrupt while any unmasked status bit is set.
  assign irq_out = |(irq_stat_q & irq_mask_q);

endmodule // rish_ref_select

// File: bench/rish_properties.sv
// Concurrent checks on the ports of the reference select block.
module rish_properties (
  input wire logic        clk_in,
  input wire logic        sys_rst_in,
  input wire logic        wb_cyc_in,
  input wire logic        wb_stb_in,
  input wire logic        wb_we_in,
  input wire logic [7:0]  wb_adr_in,
  input wire logic [3:0]  wb_sel_in,
  input wire logic [31:0] wb_dat_in,
  input wire logic [31:0] wb_dat_out,
  input wire logic        wb_ack_out,
  input wire logic [3:0]  signal_lost_flag_in,
  input wire logic        osc_pulse_in,
  input wire logic [1:0]  ref_sel_out,
  input wire logic        holdover_out,
  input wire logic        switch_pulse_out,
  input wire logic        irq_out
);
  timeunit 1ns;
  timeprecision 1ps;
  // ==========================================================================
  // Helper logic
  // ==========================================================================
  // Loss flags as seen at the previous edge, indexed by the new reference.
  logic [3:0] lost_q;
  always_ff @(posedge clk_in) begin
    lost_q <= signal_lost_flag_in;
  end
  default clocking cb @(posedge clk_in); endclocking
  default disable iff (sys_rst_in);
  // ==========================================================================
  // Bus and selection checks
  // ==========================================================================
  // A taken request is answered in the next cycle, and ack is a single pulse.
  a_ack_after_req: assert property (wb_cyc_in && wb_stb_in && !wb_ack_out |=> wb_ack_out)
    else $error("ack missing after request");
  a_ack_one_cycle: assert property (wb_ack_out |=> !wb_ack_out)
    else $error("ack longer than one cycle");
  a_ack_needs_req: assert property ($rose(wb_ack_out) |-> $past(wb_cyc_in && wb_stb_in))
    else $error("ack without request");
  // Reads above 0x14 return zero; read data holds between reads.
  a_unmapped_zero: assert property (wb_ack_out && !$past(wb_we_in) && $past(wb_adr_in) > 8'h14
    |-> wb_dat_out == 32'h0) else $error("unmapped read not zero");
  a_dat_holds: assert property (!$past(sys_rst_in)
    && !$past(wb_cyc_in && wb_stb_in && !wb_we_in && !wb_ack_out) |-> $stable(wb_dat_out))
    else $error("read data changed without read");
  // A switch moves the reference to an input that was not lost.
  a_switch_moves: assert property (switch_pulse_out |-> ref_sel_out != $past(ref_sel_out))
    else $error("switch pulse without reference change");
  a_switch_valid: assert property (switch_pulse_out |-> !lost_q[ref_sel_out])
    else $error("switched to a lost input");
  // Outputs come out of reset at their idle values.
  a_rst_outputs: assert property (disable iff (1'b0) sys_rst_in |=> ref_sel_out == 2'h0
    && !holdover_out && !switch_pulse_out && !wb_ack_out && !irq_out)
    else $error("outputs not idle after reset");
  c_switch: cover property (switch_pulse_out);
  c_holdover: cover property (holdover_out);
  c_irq: cover property ($fell(irq_out));
endmodule // rish_properties

// File: bench/testbench.sv
// Self-checking bench for the reference select block.
`include "rish_regs.vh"
module testbench;
  timeunit 1ns;
  timeprecision 1ps;
  logic        clk_in = 1'b0;
  logic        sys_rst_in = 1'b1;
  logic        wb_cyc_in = 1'b0, wb_stb_in = 1'b0, wb_we_in = 1'b0;
  logic [7:0]  wb_adr_in = 8'h00;
  logic [3:0]  wb_sel_in = 4'h0;
  logic [31:0] wb_dat_in = 32'h0;
  logic [31:0] wb_dat_out, q;
  logic        wb_ack_out, holdover_out, switch_pulse_out, irq_out, seen;
  logic [3:0]  signal_lost_flag_in = 4'h0;
  logic        osc_pulse_in = 1'b0;
  logic [1:0]  ref_sel_out, r;
  integer      error_cnt = 0, checks = 0, n, m, c;
  // ==========================================================================
  // Clock, oscillator pulse train and device
  // ==========================================================================
  // Clock at 25 MHz; oscillator rises every second clock.
  always #20 clk_in = ~clk_in;
  always @(posedge clk_in) osc_pulse_in <= ~osc_pulse_in;
  rish_ref_select #(.DIV_EXP0(2), .DIV_EXP1(3), .DIV_EXP2(4), .DIV_EXP3(5)) i_rish_ref_select (
    .clk_in(clk_in), .sys_rst_in(sys_rst_in), .wb_cyc_in(wb_cyc_in), .wb_stb_in(wb_stb_in),
    .wb_we_in(wb_we_in), .wb_adr_in(wb_adr_in), .wb_sel_in(wb_sel_in), .wb_dat_in(wb_dat_in),
    .wb_dat_out(wb_dat_out), .wb_ack_out(wb_ack_out), .signal_lost_flag_in(signal_lost_flag_in),
    .osc_pulse_in(osc_pulse_in), .ref_sel_out(ref_sel_out), .holdover_out(holdover_out),
    .switch_pulse_out(switch_pulse_out), .irq_out(irq_out));
  // ==========================================================================
  // Tasks
  // ==========================================================================
  // Compares one value and counts the result.
  task chk(input logic [31:0] got, input logic [31:0] exp);
    begin
      checks = checks + 1;
      if (got !== exp) begin
        error_cnt = error_cnt + 1;
        $display("[ERR] t=%0t got=%h exp=%h", $time, got, exp);
      end
    end
  endtask
  // One classic Wishbone cycle; data is taken at the edge that sees ack.
  task bus(input logic we, input logic [7:0] a, input logic [31:0] d);
    begin
      @(posedge clk_in);
      wb_cyc_in <= 1'b1; wb_stb_in <= 1'b1; wb_we_in <= we;
      wb_adr_in <= a; wb_dat_in <= d; wb_sel_in <= 4'hf;
      n = 0;
      do begin
        @(posedge clk_in);
        n = n + 1;
      end while (wb_ack_out !== 1'b1 && n < 20);
      chk(n < 20, 1);
      q = wb_dat_out;
      wb_cyc_in <= 1'b0; wb_stb_in <= 1'b0; wb_we_in <= 1'b0;
    end
  endtask
  task rd(input logic [7:0] a, input logic [31:0] exp);
    begin
      bus(1'b0, a, 32'h0);
      chk(q, exp);
    end
  endtask
  // Waits up to hi cycles for a switch pulse; n is the cycles waited.
  task wait_sw(input integer hi);
    begin
      n = 0;
      do begin
        @(posedge clk_in);
        n = n + 1;
      end while (switch_pulse_out !== 1'b1 && n < hi);
      seen = (switch_pulse_out === 1'b1);
    end
  endtask
  // Best valid input: highest priority, lowest index on ties.
  function automatic logic [1:0] best(input logic [7:0] p, input logic [3:0] l);
    integer i;
    logic [2:0] bp;
    begin
      best = 2'h0;
      bp = 3'h0;
      for (i = 3; i >= 0; i--) if (!l[i] && {1'b1, p[2*i+:2]} >= bp) begin
        bp = {1'b1, p[2*i+:2]};
        best = i[1:0];
      end
    end
  endfunction
  // Hold-off run: loss of current reference, switch expected in (lo, hi].
  task holdoff(input integer lo, input integer hi);
    begin
      r = ref_sel_out;
      signal_lost_flag_in <= 4'h1 << r;
      wait_sw(hi);
      chk(seen && n > lo, 1);
      chk(ref_sel_out, best(8'h55, 4'h1 << r));
      signal_lost_flag_in <= 4'h0;
    end
  endtask
  task report_and_stop;
    begin
      $display("checks=%0d error_cnt=%0d", checks, error_cnt);
      if (error_cnt == 0 && checks > 0)
        $display("NO MISMATCHES");
      else
        $display("MISMATCHES SEEN");
      $finish;
    end
  endtask
  // ==========================================================================
  // Watchdog and main sequence
  // ==========================================================================
  initial begin
    repeat (20000) @(posedge clk_in);
    error_cnt = error_cnt + 1;
    report_and_stop;
  end
  initial begin
    repeat (8) @(posedge clk_in);
    sys_rst_in <= 1'b0;
    rd(`RISH_ADR_CTRL, 32'h200);
    rd(`RISH_ADR_HOLDOFF, 32'h80);
    rd(`RISH_ADR_PRIO, 32'h1b);
    rd(8'h18, 32'h0);
    rd(`RISH_ADR_IRQ_MASK, 32'h0);
    chk(ref_sel_out, 2'h0);
    // Manual modes follow the choice field and ignore loss.
    for (m = 0; m < 4; m = m + 2) for (c = 0; c < 4; c++) begin
      bus(1'b1, `RISH_ADR_CTRL, 32'h200 | m | (c << 2));
      signal_lost_flag_in <= 4'h1 << c;
      repeat (3) @(posedge clk_in);
      chk(ref_sel_out, c[1:0]);
      chk(holdover_out, 1'b1);
    end
    signal_lost_flag_in <= 4'h0;
    // Automatic mode ignores the choice field.
    bus(1'b1, `RISH_ADR_PRIO, 32'h55);
    bus(1'b1, `RISH_ADR_CTRL, 32'h20d);
    repeat (3) @(posedge clk_in);
    r = ref_sel_out;
    bus(1'b1, `RISH_ADR_CTRL, 32'h201 | ({30'h0, ~r} << 2));
    repeat (3) @(posedge clk_in);
    chk(ref_sel_out, r);
    // Loss in automatic mode switches at once and raises the interrupt.
    bus(1'b1, `RISH_ADR_IRQ_MASK, 32'h1);
    signal_lost_flag_in <= (4'h1 << r) | 4'h1;
    wait_sw(4);
    chk(seen, 1);
    chk(ref_sel_out, best(8'h55, (4'h1 << r) | 4'h1));
    @(posedge clk_in);
    chk(irq_out, 1'b1);
    rd(`RISH_ADR_IRQ_STAT, 32'h3);
    chk(irq_out, 1'b0);
    rd(`RISH_ADR_IRQ_STAT, 32'h0);
    // A masked event leaves the interrupt low until unmasked.
    bus(1'b1, `RISH_ADR_IRQ_MASK, 32'h0);
    r = ref_sel_out;
    signal_lost_flag_in <= 4'h1 << r;
    wait_sw(4);
    chk(irq_out, 1'b0);
    bus(1'b1, `RISH_ADR_IRQ_MASK, 32'h1);
    chk(irq_out, 1'b1);
    rd(`RISH_ADR_IRQ_STAT, 32'h3);
    signal_lost_flag_in <= 4'h0;
    // Mode 11: hold-off of three ticks, eight clocks a tick.
    bus(1'b1, `RISH_ADR_HOLDOFF, 32'h3);
    bus(1'b1, `RISH_ADR_CTRL, 32'h003);
    repeat (3) @(posedge clk_in);
    holdoff(14, 40);
    // Loss that clears before zero gives no switch.
    repeat (3) @(posedge clk_in);
    r = ref_sel_out;
    signal_lost_flag_in <= 4'h1 << r;
    repeat (5) @(posedge clk_in);
    chk(holdover_out, 1'b1);
    signal_lost_flag_in <= 4'h0;
    wait_sw(60);
    chk(seen, 1'b0);
    chk(ref_sel_out, r);
    chk(holdover_out, 1'b0);
    // The counter reloads, so the next hold-off is as long again.
    holdoff(14, 40);
    // Divider code 01 doubles the tick period.
    bus(1'b1, `RISH_ADR_CTRL, 32'h103);
    repeat (3) @(posedge clk_in);
    holdoff(30, 80);
    // Revert is disregarded in mode 10 and acts at once in mode 01.
    bus(1'b1, `RISH_ADR_PRIO, 32'h57);
    bus(1'b1, `RISH_ADR_CTRL, 32'h216);
    wait_sw(6);
    chk(seen, 1'b0);
    chk(ref_sel_out, 2'h1);
    bus(1'b1, `RISH_ADR_CTRL, 32'h211);
    wait_sw(4);
    chk(seen, 1'b1);
    chk(ref_sel_out, 2'h0);
    // With every input lost no reference is left and the device holds over.
    signal_lost_flag_in <= 4'hf;
    repeat (3) @(posedge clk_in);
    chk(holdover_out, 1'b1);
    rd(`RISH_ADR_IRQ_STAT, 32'h7);
    report_and_stop;
  end
endmodule // testbench
bind rish_ref_select rish_properties i_rish_properties (
  .clk_in(clk_in), .sys_rst_in(sys_rst_in), .wb_cyc_in(wb_cyc_in), .wb_stb_in(wb_stb_in),
  .wb_we_in(wb_we_in), .wb_adr_in(wb_adr_in), .wb_sel_in(wb_sel_in), .wb_dat_in(wb_dat_in),
  .wb_dat_out(wb_dat_out), .wb_ack_out(wb_ack_out), .signal_lost_flag_in(signal_lost_flag_in),
  .osc_pulse_in(osc_pulse_in), .ref_sel_out(ref_sel_out), .holdover_out(holdover_out),
  .switch_pulse_out(switch_pulse_out), .irq_out(irq_out));
